// *** wser_defs.svh ***
// register offsets, reset values and field positions for the wake/smi event block
// Functional notes
// - wake out when status, enable, global enable
// - disabled pin still shows status, no wake
// - group five pin wake enable register
// - pin wake enable cleared only by standby
// - internal source wake enable register
// - status bus only for enabled sources
// - status a bits cleared only at source
// - status a resets 0x02, bit1 forced set
// - parallel status high until port activated
// - status b layout, reset zero
// - status b bits 2-5 write one clear
// - mouse, keyboard bits follow source only
// - keyboard pin bit write one clears
`ifndef WSER_DEFS_SVH
`define WSER_DEFS_SVH
`define WSER_OFF_PIN_EN 8'h0e
`define WSER_OFF_SRC_EN 8'h0f
`define WSER_OFF_STS_A 8'h10
`define WSER_OFF_STS_B 8'h11
`define WSER_OFF_INT_STS 8'h18
`define WSER_OFF_INT_MASK 8'h19
`define WSER_OFF_CTRL 8'h1a
`define WSER_RST_PIN_EN 8'h00
`define WSER_RST_SRC_EN 8'h00
`define WSER_RST_STS_A 8'h02
`define WSER_RST_STS_B 8'h00
`define WSER_STS_A_MASK 8'h9e
`define WSER_STS_B_MASK 8'h3f
`define WSER_STS_B_W1C 8'h3c
`define WSER_STS_B_SRC 8'h03
`define WSER_BIT_PAR 1
`endif

// *** wser_pkg.sv ***
// types for the wake/smi event block
package wser_pkg;
    typedef logic [7:0] wser_byte_type;
    typedef enum logic [1:0] {
        WSER_IDLE,
        WSER_ACK
    } wser_bus_state_type;
endpackage : wser_pkg

// *** wser_sync.sv ***
// three-stage synchroniser, change taken when last two agree
module wser_sync (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // data
    input wire logic [7:0] din,
    output logic [7:0] dout
);
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] out_q;
    wire [7:0] agree = ~(s2_q ^ s3_q);
    wire [7:0] out_d = (agree & s3_q) | (~agree & out_q);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // pins rest high; a zero here would fake an edge after reset
            s1_q <= 8'hff;
            s2_q <= 8'hff;
            s3_q <= 8'hff;
            out_q <= 8'hff;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end
    assign dout = out_q;
endmodule : wser_sync

// *** wser_edge.sv ***
// rising edge detector for event sources
module wser_edge (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // levels
    input wire logic [7:0] lvl,
    output logic [7:0] rise
);
    logic [7:0] prev_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev_q <= 8'h00;
        end else begin
            prev_q <= lvl;
        end
    end
    assign rise = lvl & ~prev_q;
endmodule : wser_edge

// *** wser_top.sv ***
// wake enable and smi status registers with wishbone slave
//
// Design decision made here: register access over Wishbone.
`include "wser_defs.svh"
module wser_top (
    // clock and resets
    input wire logic clock,
    input wire logic rst,
    input wire logic main_reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // group five pin wake status, same clock
    input wire logic [7:0] pin_wake_status,
    // internal peripheral interrupts, same clock
    input wire logic parallel_port_irq,
    input wire logic serial2_irq,
    input wire logic serial1_irq,
    input wire logic floppy_irq,
    input wire logic mouse_irq,
    input wire logic keyboard_irq,
    input wire logic watchdog_event,
    input wire logic two_wire_ctrl_event,
    input wire logic keyboard_port_pin_event,
    input wire logic parallel_port_active,
    // pins from outside
    input wire logic printer_ack_in_n,
    input wire logic ring_indicate_1_n,
    input wire logic ring_indicate_2_n,
    // outputs
    output logic wake_event_out_n,
    output logic [7:0] internal_wake_status_bus,
    output logic irq
);
    wser_pkg::wser_byte_type pin_en_q;
    wser_pkg::wser_byte_type src_en_q;
    wser_pkg::wser_byte_type sts_b_q;
    wser_pkg::wser_byte_type int_sts_q;
    wser_pkg::wser_byte_type int_mask_q;
    logic global_wake_enable_q;
    logic sts_a_forced_q;
    logic [31:0] dat_q;
    logic ack_q;
    logic err_q;
    wser_pkg::wser_bus_state_type st_q;

    // address match, shared by every register select
    function automatic logic adr_hit(input logic [7:0] adr,
        input logic [7:0] off);
        return adr == off;
    endfunction : adr_hit

    // sticky update; a set in the clearing cycle wins so no event is lost
    function automatic logic [7:0] sticky_next(input logic [7:0] cur_v,
        input logic [7:0] clr_v, input logic [7:0] set_v);
        return (cur_v & ~clr_v) | set_v;
    endfunction : sticky_next

    // pins pass the synchroniser before use
    wire [7:0] pin_raw = {5'h00, ring_indicate_2_n, ring_indicate_1_n,
        printer_ack_in_n};
    logic [7:0] pin_sync;
    wser_sync u_sync (
        .clock(clock),
        .rst(rst),
        .din(pin_raw),
        .dout(pin_sync)
    );
    wire ack_n_s = pin_sync[0];
    wire ri1_s = ~pin_sync[1];
    wire ri2_s = ~pin_sync[2];

    wire [7:0] src_lvl = {two_wire_ctrl_event, watchdog_event, keyboard_irq,
        mouse_irq, floppy_irq, serial1_irq, serial2_irq, parallel_port_irq};
    // events edge-detected so one assertion sets a sticky bit once
    wire [7:0] ev_lvl = {2'h0, ri2_s, keyboard_port_pin_event, ri1_s,
        two_wire_ctrl_event, 2'h0};
    logic [7:0] ev_rise;
    wser_edge u_edge (
        .clock(clock),
        .rst(rst),
        .lvl(ev_lvl),
        .rise(ev_rise)
    );

    // parallel status, main reset forces it high too
    wire par_sts = ~parallel_port_active | sts_a_forced_q | ack_n_s;
    wire [7:0] sts_a = {watchdog_event, 2'h0, floppy_irq, serial1_irq,
        serial2_irq, par_sts, 1'b0} & `WSER_STS_A_MASK;

    assign internal_wake_status_bus = src_lvl & src_en_q;
    wire wake_any = |(pin_wake_status & pin_en_q) & global_wake_enable_q;
    assign wake_event_out_n = ~wake_any;
    assign irq = |(int_sts_q & int_mask_q);

    // bus decode
    wire req = wb_cyc_i & wb_stb_i & (st_q == wser_pkg::WSER_IDLE);
    wire hit_pin = adr_hit(wb_adr_i, `WSER_OFF_PIN_EN);
    wire hit_src = adr_hit(wb_adr_i, `WSER_OFF_SRC_EN);
    wire hit_a = adr_hit(wb_adr_i, `WSER_OFF_STS_A);
    wire hit_b = adr_hit(wb_adr_i, `WSER_OFF_STS_B);
    wire hit_is = adr_hit(wb_adr_i, `WSER_OFF_INT_STS);
    wire hit_im = adr_hit(wb_adr_i, `WSER_OFF_INT_MASK);
    wire hit_ct = adr_hit(wb_adr_i, `WSER_OFF_CTRL);
    wire mapped = hit_pin | hit_src | hit_a | hit_b | hit_is | hit_im | hit_ct;
    wire wr = req & wb_we_i & wb_sel_i[0] & mapped;
    wire [7:0] wd = wb_dat_i[7:0];

    // status b: source bits follow source, bits 2-5 sticky with w1c, bits 6-7 zero
    wire [7:0] b_clr = (wr & hit_b) ? (wd & `WSER_STS_B_W1C) : 8'h00;
    wire [7:0] b_src = {6'h00, keyboard_irq, mouse_irq};
    wire [7:0] b_stk = sticky_next(sts_b_q, b_clr, ev_rise);
    wire [7:0] sts_b_d = ((b_stk & `WSER_STS_B_W1C) | b_src)
        & `WSER_STS_B_MASK;

    // interrupt status: set wins over write-one clear
    wire [7:0] is_clr = (wr & hit_is) ? wd : 8'h00;
    wire [7:0] is_set = {ev_rise[5:2], src_lvl[6], src_lvl[3:1]};
    wire [7:0] int_sts_d = sticky_next(int_sts_q, is_clr, is_set);

    wire [7:0] rd_byte =
        hit_pin ? pin_en_q :
        hit_src ? src_en_q :
        hit_a ? sts_a :
        hit_b ? sts_b_q :
        hit_is ? int_sts_q :
        hit_im ? int_mask_q :
        hit_ct ? {7'h00, global_wake_enable_q} : 8'h00;

    // standby reset only, these hold through main reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_en_q <= `WSER_RST_PIN_EN;
            src_en_q <= `WSER_RST_SRC_EN;
            global_wake_enable_q <= 1'b0;
        end else if (wr) begin
            if (hit_pin) pin_en_q <= wd;
            if (hit_src) src_en_q <= wd;
            if (hit_ct) global_wake_enable_q <= wd[0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sts_a_forced_q <= 1'b1;
        end else begin
            sts_a_forced_q <= main_reset;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sts_b_q <= `WSER_RST_STS_B;
            int_sts_q <= 8'h00;
            int_mask_q <= 8'h00;
        end else begin
            sts_b_q <= sts_b_d;
            int_sts_q <= int_sts_d;
            if (wr && hit_im) int_mask_q <= wd;
        end
    end

    // one registered answer a cycle after the request, ack or err for one cycle then idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= wser_pkg::WSER_IDLE;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            case (st_q)
                wser_pkg::WSER_IDLE: begin
                    ack_q <= req & mapped;
                    err_q <= req & ~mapped;
                    dat_q <= {24'h000000, rd_byte};
                    if (req) st_q <= wser_pkg::WSER_ACK;
                end
                wser_pkg::WSER_ACK: begin
                    ack_q <= 1'b0;
                    err_q <= 1'b0;
                    st_q <= wser_pkg::WSER_IDLE;
                end
                default: begin
                    st_q <= wser_pkg::WSER_IDLE;
                end
            endcase
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = dat_q;

    property p_wake;
        @(posedge clock) disable iff (rst)
        (|(pin_wake_status & pin_en_q) && global_wake_enable_q)
            |-> !wake_event_out_n;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not driven");
    property p_nowake;
        @(posedge clock) disable iff (rst)
        !global_wake_enable_q |-> wake_event_out_n;
    endproperty
    a_nowake: assert property (p_nowake) else $error("wake leak");
    property p_bus;
        @(posedge clock) disable iff (rst)
        (internal_wake_status_bus & ~src_en_q) == 8'h00;
    endproperty
    a_bus: assert property (p_bus) else $error("bus leak");
    property p_par;
        @(posedge clock) disable iff (rst)
        !parallel_port_active |-> sts_a[1];
    endproperty
    a_par: assert property (p_par) else $error("parallel not high");
    property p_res;
        @(posedge clock) disable iff (rst)
        (sts_b_q & ~`WSER_STS_B_MASK) == 8'h00 && !sts_a[0];
    endproperty
    a_res: assert property (p_res) else $error("reserved set");
    property p_w1c;
        @(posedge clock) disable iff (rst)
        (wr && hit_b && wd[3] && !ev_rise[3]) |=> !sts_b_q[3];
    endproperty
    a_w1c: assert property (p_w1c) else $error("w1c failed");
    property p_src;
        @(posedge clock) disable iff (rst)
        ##1 sts_b_q[1:0] == $past({keyboard_irq, mouse_irq});
    endproperty
    a_src: assert property (p_src) else $error("src bits wrong");
    property p_ack;
        @(posedge clock) disable iff (rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held");

    // enables move only on a register write
    property p_pin_keep;
        @(posedge clock) disable iff (rst)
        !(wr && hit_pin) |=> $stable(pin_en_q);
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("pin en lost");

    property p_pin_load;
        @(posedge clock) disable iff (rst)
        (wr && hit_pin) |=> pin_en_q == $past(wd);
    endproperty
    a_pin_load: assert property (p_pin_load) else $error("pin en wr");

    property p_src_keep;
        @(posedge clock) disable iff (rst)
        !(wr && hit_src) |=> $stable(src_en_q);
    endproperty
    a_src_keep: assert property (p_src_keep) else $error("src en lost");

    property p_src_load;
        @(posedge clock) disable iff (rst)
        (wr && hit_src) |=> src_en_q == $past(wd);
    endproperty
    a_src_load: assert property (p_src_load) else $error("src en wr");

    // status registers
    property p_force;
        @(posedge clock) disable iff (rst)
        main_reset |=> sts_a[1];
    endproperty
    a_force: assert property (p_force) else $error("not forced");

    property p_follow;
        @(posedge clock) disable iff (rst)
        (parallel_port_active && !sts_a_forced_q) |-> sts_a[1] == ack_n_s;
    endproperty
    a_follow: assert property (p_follow) else $error("no follow");

    property p_rd_a;
        @(posedge clock) disable iff (rst)
        (req && hit_a && !wb_we_i) |=> wb_dat_o[7:0] == $past(sts_a);
    endproperty
    a_rd_a: assert property (p_rd_a) else $error("read a");

    property p_rd_b;
        @(posedge clock) disable iff (rst)
        (req && hit_b && !wb_we_i) |=> wb_dat_o[7:0] == $past(sts_b_q);
    endproperty
    a_rd_b: assert property (p_rd_b) else $error("read b");

    property p_b_set;
        @(posedge clock) disable iff (rst)
        (ev_rise[5:2] != 4'h0)
            |=> (sts_b_q[5:2] & $past(ev_rise[5:2])) == $past(ev_rise[5:2]);
    endproperty
    a_b_set: assert property (p_b_set) else $error("event lost");

    property p_b_keep;
        @(posedge clock) disable iff (rst)
        (!(wr && hit_b) && ev_rise[5:2] == 4'h0)
            |=> $stable(sts_b_q[5:2]);
    endproperty
    a_b_keep: assert property (p_b_keep) else $error("sticky moved");

    property p_pin_clr;
        @(posedge clock) disable iff (rst)
        (wr && hit_b && wd[4] && !ev_rise[4]) |=> !sts_b_q[4];
    endproperty
    a_pin_clr: assert property (p_pin_clr) else $error("pin bit kept");

    // wake output
    property p_disabled;
        @(posedge clock) disable iff (rst)
        (pin_wake_status & pin_en_q) == 8'h00 |-> wake_event_out_n;
    endproperty
    a_disabled: assert property (p_disabled) else $error("wake unasked");

    property p_wake_cause;
        @(posedge clock) disable iff (rst)
        !wake_event_out_n |-> global_wake_enable_q;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("no enable");

    // bus handshake, one answer then idle
    sequence s_take;
        req && mapped;
    endsequence
    sequence s_answer;
        wb_ack_o && !wb_err_o ##1 !wb_ack_o;
    endsequence
    sequence s_refuse;
        wb_err_o && !wb_ack_o ##1 !wb_err_o;
    endsequence

    property p_answer;
        @(posedge clock) disable iff (rst)
        s_take |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");

    property p_refuse;
        @(posedge clock) disable iff (rst)
        (req && !mapped) |=> s_refuse;
    endproperty
    a_refuse: assert property (p_refuse) else $error("no refusal");

    property p_upper;
        @(posedge clock) disable iff (rst)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
endmodule : wser_top

// *** wser_tb.sv ***
// self-checking bench for the wake and smi event registers
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic main_reset = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    logic [7:0] pin_wake_status = 8'h00;
    // bit order of the internal wake status bus
    logic [7:0] src = 8'h00;
    logic kbd_pin = 1'b0;
    logic active = 1'b0;
    logic ack_n = 1'b1;
    logic ri1_n = 1'b1;
    logic ri2_n = 1'b1;
    logic wake_n;
    logic [7:0] st_bus;
    logic irq;
    logic [7:0] rd;
    logic er;
    int failures = 0;
    int n_compared = 0;

    wser_top dut_u (.clock(clock), .rst(rst), .main_reset(main_reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .pin_wake_status(pin_wake_status), .parallel_port_irq(src[0]),
        .serial2_irq(src[1]), .serial1_irq(src[2]), .floppy_irq(src[3]),
        .mouse_irq(src[4]), .keyboard_irq(src[5]), .watchdog_event(src[6]),
        .two_wire_ctrl_event(src[7]), .keyboard_port_pin_event(kbd_pin),
        .parallel_port_active(active), .printer_ack_in_n(ack_n),
        .ring_indicate_1_n(ri1_n), .ring_indicate_2_n(ri2_n),
        .wake_event_out_n(wake_n), .internal_wake_status_bus(st_bus),
        .irq(irq));

    always #2 clock = ~clock;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    // one classic cycle; ack or err sampled at the edge before release
    // no limit here: only the watchdog ends a wait
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o[7:0];
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : bus

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask : rdc

    task automatic t_reset;
        rdc(8'h0e, 8'h00);
        rdc(8'h0f, 8'h00);
        rdc(8'h10, 8'h02);
        rdc(8'h11, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_wake;
        bus(1'b1, 8'h0e, 8'h5a);
        rdc(8'h0e, 8'h5a);
        bus(1'b1, 8'h1a, 8'h01);
        rdc(8'h1a, 8'h01);
        pin_wake_status <= 8'h01;
        cyc(3);
        chk({7'h0, wake_n}, 8'h01);
        pin_wake_status <= 8'h02;
        cyc(3);
        chk({7'h0, wake_n}, 8'h00);
        bus(1'b1, 8'h1a, 8'h00);
        cyc(2);
        chk({7'h0, wake_n}, 8'h01);
        pin_wake_status <= 8'h00;
        $display("test wake done");
    endtask : t_wake

    task automatic t_src;
        bus(1'b1, 8'h0f, 8'hff);
        rdc(8'h0f, 8'hff);
        for (int i = 0; i < 8; i++) begin
            src <= 8'h01 << i;
            cyc(3);
            chk(st_bus, 8'h01 << i);
        end
        bus(1'b1, 8'h0f, 8'h7e);
        src <= 8'hff;
        cyc(3);
        chk(st_bus, 8'h7e);
        src <= 8'h00;
        $display("test source enable done");
    endtask : t_src

    task automatic t_sts_a;
        cyc(1);
        active <= 1'b1;
        ack_n <= 1'b0;
        src <= 8'h4e;
        cyc(8);
        rdc(8'h10, 8'h9c);
        bus(1'b1, 8'h10, 8'h00);
        rdc(8'h10, 8'h9c);
        ack_n <= 1'b1;
        cyc(8);
        rdc(8'h10, 8'h9e);
        ack_n <= 1'b0;
        main_reset <= 1'b1;
        cyc(3);
        rdc(8'h10, 8'h9e);
        rdc(8'h0e, 8'h5a);
        main_reset <= 1'b0;
        src <= 8'h00;
        active <= 1'b0;
        cyc(8);
        rdc(8'h10, 8'h02);
        ack_n <= 1'b1;
        $display("test status a done");
    endtask : t_sts_a

    task automatic t_sts_b;
        bus(1'b1, 8'h11, 8'hff);
        rdc(8'h11, 8'h00);
        src <= 8'h30;
        cyc(3);
        bus(1'b1, 8'h11, 8'h03);
        rdc(8'h11, 8'h03);
        src <= 8'h80;
        kbd_pin <= 1'b1;
        ri1_n <= 1'b0;
        ri2_n <= 1'b0;
        cyc(8);
        rdc(8'h11, 8'h3c);
        bus(1'b1, 8'h11, 8'h00);
        rdc(8'h11, 8'h3c);
        // pin still high: a level must not set it again
        bus(1'b1, 8'h11, 8'h10);
        rdc(8'h11, 8'h2c);
        bus(1'b1, 8'h11, 8'h2c);
        rdc(8'h11, 8'h00);
        src <= 8'h00;
        kbd_pin <= 1'b0;
        ri1_n <= 1'b1;
        ri2_n <= 1'b1;
        $display("test status b done");
    endtask : t_sts_b

    task automatic t_irq;
        cyc(8);
        bus(1'b1, 8'h19, 8'h00);
        bus(1'b1, 8'h18, 8'hff);
        rdc(8'h18, 8'h00);
        src <= 8'h80;
        cyc(3);
        src <= 8'h00;
        cyc(3);
        rdc(8'h18, 8'h10);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, 8'h19, 8'h10);
        cyc(2);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, 8'h18, 8'h10);
        cyc(2);
        chk({7'h0, irq}, 8'h00);
        bus(1'b0, 8'h20, 8'h00);
        chk({7'h0, er}, 8'h01);
        $display("test interrupt done");
    endtask : t_irq

    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_wake();
        t_src();
        t_sts_a();
        t_sts_b();
        t_irq();
        end_sim();
    end
endmodule : testbench
